// >>> logic/ppm_consts.svh
// constants of the profile pin modulation select block
// assumes a single 40 MHz ref_clk and a plain strobe register port
`ifndef PPM_CONSTS_SVH
`define PPM_CONSTS_SVH

// register byte offsets
`define PPM_OFF_FR1        8'h00
`define PPM_OFF_CFR        8'h04
`define PPM_OFF_STATUS     8'h08

// function_register_one fields
`define PPM_FR1_LEVEL_LSB  8
`define PPM_FR1_RAMP_LSB   10
`define PPM_FR1_ASSIGN_LSB 12
// channel_function_register fields
`define PPM_CFR_SWEEP_BIT  14
`define PPM_CFR_MODT_LSB   22

// reset values
`define PPM_RST_FR1        32'h0000_0000
`define PPM_RST_CFR        32'h0000_0000

// word addresses of the selected profile
`define PPM_ADDR_FREQ0     8'h04
`define PPM_ADDR_PHASE0    8'h05
`define PPM_ADDR_AMPL0     8'h06
`define PPM_ADDR_PROFILE1  8'h0A

`endif

// >>> logic/ppm_pkg.sv
// types of the profile pin modulation select block
// assumes ppm_consts.svh for the register constants; enum codes are set here
package ppm_pkg;

    typedef enum logic [1:0] {
        ramp_off    = 2'b00,
        ramp_p23    = 2'b01,
        ramp_p3     = 2'b10,
        ramp_serial = 2'b11
    } ppm_ramp_src_type;

    typedef enum logic [1:0] {
        level_two     = 2'b00,
        level_four    = 2'b01,
        level_eight   = 2'b10,
        level_sixteen = 2'b11
    } ppm_level_type;

    typedef enum logic [1:0] {
        mod_off       = 2'b00,
        mod_amplitude = 2'b01,
        mod_frequency = 2'b10,
        mod_phase     = 2'b11
    } ppm_mod_type_type;

    // function_register_one, the fields this block uses
    typedef struct packed {
        logic [2:0]       pin_assignment_config;
        ppm_ramp_src_type ramp_src;
        ppm_level_type    level;
    } ppm_fr1_type;

    // channel_function_register, the fields this block uses
    typedef struct packed {
        ppm_mod_type_type modulation_type_select;
        logic             sweep_enable;
    } ppm_cfr_type;

    // selection result toward the primary_channel datapath
    typedef struct packed {
        logic       config_error;
        logic       single_bit_io;
        logic       mod_active;
        logic       ramp_active;
        logic       ramp_down;
        logic [7:0] word_addr;
        logic [3:0] profile_index;
    } ppm_sel_type;

    // whole state of the block
    typedef struct packed {
        ppm_fr1_type fr1;
        ppm_cfr_type channel_function_register;
        logic [6:0]  sync1;
        logic [6:0]  sync2;
        logic [6:0]  sync3;
        logic [6:0]  pins;
        ppm_sel_type sel;
        logic [31:0] rdata;
    } ppm_state_type;

endpackage : ppm_pkg

// >>> logic/ppm_select.sv
// profile pin and serial pin decoder for primary_channel shift keying
// assumes pins are asynchronous to ref_clk and registers come over a
// one-cycle strobe port with read data in the following cycle
//
// The strobed register port and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
`include "ppm_consts.svh"

module ppm_select (
    // clock and reset
    input  wire logic                ref_clk,
    input  wire logic                rstn,
    // register port
    input  wire logic [7:0]          reg_addr,
    input  wire logic [31:0]         reg_wdata,
    input  wire logic                reg_write,
    input  wire logic                reg_read,
    output logic [31:0]              reg_rdata,
    // pins from the external controller
    input  wire logic [3:0]          profile_pin,
    input  wire logic [2:0]          serial_data_pin,
    // selection result
    output ppm_pkg::ppm_sel_type     select
);

    ppm_pkg::ppm_state_type state;
    ppm_pkg::ppm_state_type next_state;

    // word address of a profile index for the modulated parameter
    function automatic logic [7:0] word_addr_of(
        input ppm_pkg::ppm_mod_type_type mt,
        input logic [3:0]                idx
    );
        logic [7:0] a;
        a = `PPM_ADDR_FREQ0;
        if (idx == 4'h0) begin
            unique case (mt)
                ppm_pkg::mod_phase:     a = `PPM_ADDR_PHASE0;
                ppm_pkg::mod_amplitude: a = `PPM_ADDR_AMPL0;
                default:                a = `PPM_ADDR_FREQ0;
            endcase
        end else begin
            a = `PPM_ADDR_PROFILE1 + {4'h0, idx} - 8'h01;
        end
        return a;
    endfunction : word_addr_of

    // pins: bits 3..0 profile pins three..zero, bits 6..4 serial 3..1
    function automatic ppm_pkg::ppm_sel_type decode(
        input ppm_pkg::ppm_fr1_type fr1,
        input ppm_pkg::ppm_cfr_type channel_function_register,
        input logic [6:0]           pins,
        input logic                 prev_down
    );
        ppm_pkg::ppm_sel_type r;
        logic [3:0]           p;
        logic [2:0]           s;
        logic                 ok;
        logic [2:0]           pa;
        r  = '0;
        p  = pins[3:0];
        s  = pins[6:4];
        ok = 1'b1;
        pa = fr1.pin_assignment_config;
        unique case (fr1.ramp_src)
            ppm_pkg::ramp_off: begin
                unique case (fr1.level)
                    ppm_pkg::level_two:
                        r.profile_index = {3'b000, p[1]};
                    ppm_pkg::level_four:
                        if (pa == 3'b011) begin
                            r.profile_index = {2'b00, p[0], p[1]};
                        end else begin
                            ok = 1'b0;
                        end
                    ppm_pkg::level_eight:
                        if (pa[1:0] == 2'b01) begin
                            r.profile_index = {1'b0, p[0], p[1], p[2]};
                        end else begin
                            ok = 1'b0;
                        end
                    ppm_pkg::level_sixteen:
                        if (pa[1:0] == 2'b01) begin
                            r.profile_index = {p[0], p[1], p[2], p[3]};
                        end else begin
                            ok = 1'b0;
                        end
                endcase
            end
            ppm_pkg::ramp_p23: begin
                r.ramp_active = 1'b1;
                if (fr1.level != ppm_pkg::level_two) begin
                    ok = 1'b0;
                end else if (pa == 3'b000) begin
                    r.profile_index = {3'b000, p[1]};
                    r.ramp_down     = p[3];
                end else if (pa == 3'b011) begin
                    r.profile_index = {3'b000, p[0]};
                    r.ramp_down     = p[2];
                end else begin
                    ok = 1'b0;
                end
            end
            ppm_pkg::ramp_p3: begin
                r.ramp_active = 1'b1;
                if (fr1.level == ppm_pkg::level_eight && pa[1:0] == 2'b01) begin
                    r.profile_index = {1'b0, p[0], p[1], p[2]};
                    r.ramp_down     = p[3];
                end else begin
                    ok = 1'b0;
                end
            end
            ppm_pkg::ramp_serial: begin
                r.ramp_active   = 1'b1;
                r.single_bit_io = 1'b1;
                unique case (fr1.level)
                    ppm_pkg::level_two: begin
                        r.profile_index = {3'b000, p[1]};
                        // other patterns hold the last request
                        if (s == 3'b010) begin
                            r.ramp_down = 1'b0;
                        // s holds serial pins 3..1, so pattern 0,1,1 is 110
                        end else if (s == 3'b110) begin
                            r.ramp_down = 1'b1;
                        end else begin
                            r.ramp_down = prev_down;
                        end
                    end
                    ppm_pkg::level_four:
                        if (pa == 3'b000) begin
                            r.profile_index = {2'b00, p[2], p[3]};
                            r.ramp_down     = s[1];
                        end else if (pa == 3'b011) begin
                            r.profile_index = {2'b00, p[0], p[1]};
                            r.ramp_down     = s[0];
                        end else begin
                            ok = 1'b0;
                        end
                    ppm_pkg::level_sixteen:
                        if (pa[1:0] == 2'b01) begin
                            r.profile_index = {p[0], p[1], p[2], p[3]};
                            r.ramp_down     = s[0];
                        end else begin
                            ok = 1'b0;
                        end
                    default:
                        ok = 1'b0;
                endcase
            end
        endcase
        // sweep must be off while modulating
        r.config_error = !ok
            || (channel_function_register.sweep_enable
                && channel_function_register.modulation_type_select != ppm_pkg::mod_off);
        r.mod_active = ok && !channel_function_register.sweep_enable
            && channel_function_register.modulation_type_select != ppm_pkg::mod_off;
        if (!ok) begin
            r.ramp_active = 1'b0;
            r.ramp_down   = 1'b0;
        end
        // a broken setup parks the channel on its initial word
        if (!r.mod_active) begin
            r.profile_index = 4'h0;
        end
        r.word_addr = word_addr_of(channel_function_register.modulation_type_select,
                                   r.profile_index);
        return r;
    endfunction : decode

    always_comb begin
        next_state       = state;
        next_state.rdata = 32'h0000_0000;
        // three-stage synchroniser; a bit counts once stages two and
        // three agree, which also rejects single-cycle glitches
        next_state.sync1 = {serial_data_pin, profile_pin};
        next_state.sync2 = state.sync1;
        next_state.sync3 = state.sync2;
        next_state.pins  = (state.sync2 & state.sync3)
                         | (state.pins & (state.sync2 ^ state.sync3));
        next_state.sel   = decode(state.fr1, state.channel_function_register, state.pins,
                                  state.sel.ramp_down);
        if (reg_write) begin
            unique case (reg_addr)
                `PPM_OFF_FR1: begin
                    next_state.fr1.level = ppm_pkg::ppm_level_type'(
                        reg_wdata[`PPM_FR1_LEVEL_LSB +: 2]);
                    next_state.fr1.ramp_src = ppm_pkg::ppm_ramp_src_type'(
                        reg_wdata[`PPM_FR1_RAMP_LSB +: 2]);
                    next_state.fr1.pin_assignment_config =
                        reg_wdata[`PPM_FR1_ASSIGN_LSB +: 3];
                end
                `PPM_OFF_CFR: begin
                    next_state.channel_function_register.sweep_enable =
                        reg_wdata[`PPM_CFR_SWEEP_BIT];
                    next_state.channel_function_register.modulation_type_select =
                        ppm_pkg::ppm_mod_type_type'(
                        reg_wdata[`PPM_CFR_MODT_LSB +: 2]);
                end
                default: begin
                end
            endcase
        end
        if (reg_read) begin
            unique case (reg_addr)
                `PPM_OFF_FR1: begin
                    next_state.rdata[`PPM_FR1_LEVEL_LSB +: 2] =
                        state.fr1.level;
                    next_state.rdata[`PPM_FR1_RAMP_LSB +: 2] =
                        state.fr1.ramp_src;
                    next_state.rdata[`PPM_FR1_ASSIGN_LSB +: 3] =
                        state.fr1.pin_assignment_config;
                end
                `PPM_OFF_CFR: begin
                    next_state.rdata[`PPM_CFR_SWEEP_BIT] =
                        state.channel_function_register.sweep_enable;
                    next_state.rdata[`PPM_CFR_MODT_LSB +: 2] =
                        state.channel_function_register.modulation_type_select;
                end
                `PPM_OFF_STATUS: begin
                    next_state.rdata[25:0] = {state.sel, state.pins};
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            state     <= '0;
            state.fr1 <= ppm_pkg::ppm_fr1_type'(`PPM_RST_FR1);
            state.channel_function_register <= ppm_pkg::ppm_cfr_type'(`PPM_RST_CFR);
        end else begin
            state <= next_state;
        end
    end

    assign reg_rdata = state.rdata;
    assign select    = state.sel;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    ramp_off_a: assert property (
        state.fr1.ramp_src == ppm_pkg::ramp_off
        |=> !select.ramp_active)
        else $error("ramp active with ramp source off");

    single_bit_a: assert property (
        state.fr1.ramp_src == ppm_pkg::ramp_serial
        |=> select.single_bit_io)
        else $error("serial ramp source without single-bit mode");

    pin_ramp_pol_a: assert property (
        state.fr1.ramp_src == ppm_pkg::ramp_p3
        && state.fr1.level == ppm_pkg::level_eight
        && state.fr1.pin_assignment_config[1:0] == 2'b01
        |=> select.ramp_down == $past(state.pins[3]))
        else $error("profile pin three ramp polarity wrong");

    bad_assign_a: assert property (
        state.fr1.ramp_src == ppm_pkg::ramp_off
        && state.fr1.level == ppm_pkg::level_four
        && state.fr1.pin_assignment_config != 3'b011
        |=> select.config_error && !select.mod_active)
        else $error("illegal pin assignment not flagged");

    two_level_a: assert property (
        state.fr1.ramp_src == ppm_pkg::ramp_off
        && state.fr1.level == ppm_pkg::level_two
        && state.channel_function_register.modulation_type_select != ppm_pkg::mod_off
        && !state.channel_function_register.sweep_enable
        |=> select.profile_index == {3'b000, $past(state.pins[1])})
        else $error("two-level index not from profile pin one");

    sixteen_level_a: assert property (
        state.fr1.ramp_src == ppm_pkg::ramp_off
        && state.fr1.level == ppm_pkg::level_sixteen
        && state.fr1.pin_assignment_config[1:0] == 2'b01
        && state.channel_function_register.modulation_type_select == ppm_pkg::mod_frequency
        && !state.channel_function_register.sweep_enable && state.pins[3:0] == 4'b0111
        |=> select.profile_index == 4'hE && select.word_addr == 8'h17)
        else $error("pattern 1110 did not pick profile 14");

    serial_up_a: assert property (
        state.fr1.ramp_src == ppm_pkg::ramp_serial
        && state.fr1.level == ppm_pkg::level_two
        && state.pins[6:4] == 3'b010
        ##1 state.pins[6:4] == 3'b111
        |=> !select.ramp_down && select.ramp_active)
        else $error("serial ramp-up request not held");

    sweep_block_a: assert property (
        state.channel_function_register.sweep_enable
        |=> !select.mod_active ##1 !select.mod_active
            || !$past(state.channel_function_register.sweep_enable))
        else $error("modulation active with sweep enabled");

    addr_map_a: assert property (
        select.profile_index != 4'h0
        |-> select.word_addr == 8'h09 + {4'h0, select.profile_index})
        else $error("profile word address off");

    pin_latency_a: assert property (
        $rose(state.sync3[1]) && state.sync2[1] |=> state.pins[1])
        else $error("pin change not accepted when stages agree");

    read_once_a: assert property (
        !reg_read |=> reg_rdata == 32'h0000_0000)
        else $error("read data outside its cycle");

    cover_serial_c: cover property (
        select.ramp_active && select.single_bit_io && select.ramp_down);
    cover_sixteen_c: cover property (
        select.mod_active && select.profile_index == 4'hF);
    cover_error_c: cover property (select.config_error);

endmodule : ppm_select

// >>> bench/ppm_pin_ctrl.sv
// model of the external controller that drives the profile and serial pins
// assumes one ref_clk; pins change only just after a rising edge
`timescale 1ns/10ps

module ppm_pin_ctrl (
    // clock
    input  wire logic       ref_clk,
    // request from the bench
    input  wire logic       load,
    input  wire logic       slow,
    input  wire logic [6:0] pins_in,
    input  wire logic       single_bit_io,
    // pins toward the device
    output logic [3:0]      profile_pin,
    output logic [2:0]      serial_data_pin
);
    logic [2:0] pend;
    logic [1:0] wait_cnt;

    initial begin
        profile_pin     = 4'h0;
        serial_data_pin = 3'h0;
        pend            = 3'h0;
        wait_cnt        = 2'h0;
    end

    // serial pins take pins_in[6:4] on a fast load, or three cycles after a slow one, whatever single_bit_io is; that input is not used here
    // ramp pins driven low for up, high for down
    always @(posedge ref_clk) begin
        if (load) begin
            profile_pin <= pins_in[3:0];
            pend        <= pins_in[6:4];
            wait_cnt    <= slow ? 2'h3 : 2'h0;
            if (!slow) begin
                serial_data_pin <= pins_in[6:4];
            end
        end else if (wait_cnt == 2'h1) begin
            // slow controller: serial levels lag the profile pins
            serial_data_pin <= pend;
            wait_cnt        <= 2'h0;
        end else if (wait_cnt != 2'h0) begin
            wait_cnt <= wait_cnt - 2'h1;
        end
    end
endmodule : ppm_pin_ctrl

// >>> bench/test_profile_pin_modulation_select.sv
// self-checking bench of the profile pin modulation select block
// assumes ppm_select, ppm_pkg and ppm_pin_ctrl are compiled before it
`timescale 1ns/10ps
`include "ppm_consts.svh"

`define CHECK(what, exp, got) begin checks++; if ((got) !== (exp)) begin \
    miscompares++; $display("ERROR %s exp %h got %h", what, exp, got); end end

module test_profile_pin_modulation_select;
    logic                 ref_clk;
    logic                 rstn;
    logic [7:0]           reg_addr;
    logic [31:0]          reg_wdata;
    logic                 reg_write;
    logic                 reg_read;
    logic [31:0]          reg_rdata;
    logic [3:0]           profile_pin;
    logic [2:0]           serial_data_pin;
    ppm_pkg::ppm_sel_type select;
    logic                 load;
    logic                 slow;
    logic [6:0]           pins_in;
    logic [31:0]          lfsr;
    int                   miscompares;
    int                   checks;
    // corners: {assign, ramp, level, type, sweep, serial, profile}
    logic [16:0] corner [15] = '{17'h0_0200, 17'h0_0202, 17'h0_C703,
        17'h1_4907, 17'h0_4E07, 17'h0_7E1B, 17'h0_110A, 17'h0_D301,
        17'h1_6A05, 17'h0_362C, 17'h0_F262, 17'h0_0282, 17'h0_0603,
        17'h0_7A00, 17'h0_C403};

    ppm_select u_dut (
        .ref_clk         (ref_clk),
        .rstn            (rstn),
        .reg_addr        (reg_addr),
        .reg_wdata       (reg_wdata),
        .reg_write       (reg_write),
        .reg_read        (reg_read),
        .reg_rdata       (reg_rdata),
        .profile_pin     (profile_pin),
        .serial_data_pin (serial_data_pin),
        .select          (select)
    );

    ppm_pin_ctrl u_ctrl (
        .ref_clk         (ref_clk),
        .load            (load),
        .slow            (slow),
        .pins_in         (pins_in),
        .single_bit_io   (select.single_bit_io),
        .profile_pin     (profile_pin),
        .serial_data_pin (serial_data_pin)
    );

    function automatic logic [31:0] next_rand(input logic [31:0] v);
        return {v[30:0], 1'b0} ^ (v[31] ? 32'h0400_0007 : 32'h0000_0000);
    endfunction : next_rand

    function automatic ppm_pkg::ppm_sel_type exp_sel(input logic [16:0] c);
        logic [2:0]           a;
        logic [1:0]           r;
        logic [1:0]           l;
        logic [1:0]           m;
        logic [2:0]           s;
        logic [3:0]           p;
        logic                 ok;
        logic [3:0]           ix;
        ppm_pkg::ppm_sel_type e;
        {a, r, l, m} = c[16:8];
        s = c[6:4];
        p = c[3:0];
        e = '0;
        case (r)
            2'd0: ok = l == 2'd0 || (l == 2'd1 && a == 3'b011)
                       || (l[1] && a[1:0] == 2'b01);
            2'd1: ok = l == 2'd0 && (a == 3'b000 || a == 3'b011);
            2'd2: ok = l == 2'd2 && a[1:0] == 2'b01;
            default: ok = l == 2'd0 || (l == 2'd3 && a[1:0] == 2'b01)
                          || (l == 2'd1 && (a == 3'b000 || a == 3'b011));
        endcase
        case (l)
            2'd0: ix = {3'h0, (r == 2'd1 && a == 3'b011) ? p[0] : p[1]};
            2'd1: ix = (r == 2'd3 && a == 3'b000) ? {2'h0, p[2], p[3]}
                                                   : {2'h0, p[0], p[1]};
            2'd2: ix = {1'b0, p[0], p[1], p[2]};
            default: ix = {p[0], p[1], p[2], p[3]};
        endcase
        e.single_bit_io = r == 2'd3;
        e.config_error  = !ok || (m != 2'd0 && c[7]);
        e.mod_active    = ok && m != 2'd0 && !c[7];
        e.ramp_active   = ok && r != 2'd0;
        case (r)
            2'd1: e.ramp_down = (a == 3'b000) ? p[3] : p[2];
            2'd2: e.ramp_down = p[3];
            default: e.ramp_down = (l == 2'd0) ? s[2]
                : (l == 2'd1 && a == 3'b000) ? s[1] : s[0];
        endcase
        if (!e.ramp_active) begin
            e.ramp_down = 1'b0;
        end
        e.profile_index = e.mod_active ? ix : 4'h0;
        if (e.profile_index == 4'h0) begin
            e.word_addr = (m == 2'd1) ? `PPM_ADDR_AMPL0
                        : (m == 2'd3) ? `PPM_ADDR_PHASE0 : `PPM_ADDR_FREQ0;
        end else begin
            e.word_addr = `PPM_ADDR_PROFILE1 + {4'h0, e.profile_index} - 8'h01;
        end
        return e;
    endfunction : exp_sel

    task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_write <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_write <= 1'b0;
    endtask : bus_wr

    task automatic bus_rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge ref_clk);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_read <= 1'b0;
        #1;
        `CHECK("reg_rdata", exp, reg_rdata)
        @(posedge ref_clk);
        #1;
        `CHECK("rdata_idle", 32'h0000_0000, reg_rdata)
    endtask : bus_rd

    task automatic run_case(input logic [16:0] c);
        ppm_pkg::ppm_sel_type e;
        logic [31:0]          f;
        logic [31:0]          g;
        e = exp_sel(c);
        lfsr = next_rand(lfsr);
        @(posedge ref_clk);
        load    <= 1'b1;
        slow    <= lfsr[3];
        pins_in <= c[6:0];
        @(posedge ref_clk);
        load <= 1'b0;
        // unused bits carry noise, except CFR bits 21:15 which are zero; none must read back
        f = {lfsr[31:15], c[16:10], lfsr[7:0]};
        g = {lfsr[15:8], c[9:8], 7'h00, c[7], lfsr[13:0]};
        bus_wr(`PPM_OFF_FR1, f);
        bus_wr(`PPM_OFF_CFR, g);
        repeat (12) @(posedge ref_clk);
        #1;
        `CHECK("config_error", e.config_error, select.config_error)
        `CHECK("single_bit_io", e.single_bit_io, select.single_bit_io)
        `CHECK("mod_active", e.mod_active, select.mod_active)
        `CHECK("ramp_active", e.ramp_active, select.ramp_active)
        if (e.ramp_active) begin
            `CHECK("ramp_down", e.ramp_down, select.ramp_down)
        end
        `CHECK("word_addr", e.word_addr, select.word_addr)
        `CHECK("profile_index", e.profile_index, select.profile_index)
        bus_rd(`PPM_OFF_FR1, f & 32'h0000_7F00);
        bus_rd(`PPM_OFF_CFR, g & 32'h00C0_4000);
        bus_rd(`PPM_OFF_STATUS, {6'h00, e, c[6:0]});
        bus_rd(8'h0C, 32'h0000_0000);
    endtask : run_case

    task automatic complete_run;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : complete_run

    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    initial begin
        repeat (20000) @(posedge ref_clk);
        miscompares++;
        complete_run();
    end

    initial begin
        logic [16:0] c;
        rstn = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 32'h0000_0000;
        reg_write = 1'b0;
        reg_read = 1'b0;
        load = 1'b0;
        slow = 1'b0;
        pins_in = 7'h00;
        lfsr = 32'h1a01_b4fb;
        miscompares = 0;
        checks = 0;
        repeat (16) @(posedge ref_clk);
        rstn <= 1'b1;
        repeat (3) @(posedge ref_clk);
        #1;
        `CHECK("select_reset", 19'h0_0040, select)
        foreach (corner[i]) begin
            run_case(corner[i]);
            $display("corner test %0d done", i);
        end
        for (int n = 0; n < 60; n++) begin
            lfsr = next_rand(lfsr);
            c = lfsr[16:0];
            // two-level serial ramp only uses the two defined patterns
            if (c[13:12] == 2'd3 && c[11:10] == 2'd0) begin
                c[5:4] = 2'b10;
            end
            run_case(c);
            $display("random test %0d done", n);
        end
        // reset in mid-run clears the registers and the selection
        @(posedge ref_clk);
        rstn <= 1'b0;
        #1;
        `CHECK("select_in_reset", 19'h0_0000, select)
        repeat (2) @(posedge ref_clk);
        rstn <= 1'b1;
        repeat (2) @(posedge ref_clk);
        bus_rd(`PPM_OFF_FR1, 32'h0000_0000);
        $display("reset test done");
        complete_run();
    end
endmodule : test_profile_pin_modulation_select
